// file: pkg/vr_fault_pkg.sv
// Shared constants and types for the regulator fault supervisor.
package vr_fault_pkg;
    // --------------------
    // Clock and timing
    // --------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OC_ALERT_MAX_NS = 2000;
    localparam int OC_TIMER_MIN_NS = 7500;
    localparam int OC_TIMER_MAX_NS = 11000;
    localparam int OTHER_OFF_MAX_NS = 10000;
    localparam int THERM_SHUT_MIN_NS = 100000;
    localparam int BAL_FAULT_NS = 1000000;
    localparam int OC_TIMER_CYC = (OC_TIMER_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int THERM_SHUT_CYC = (THERM_SHUT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BAL_FAULT_CYC = (BAL_FAULT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // --------------------
    // Synchronised input positions
    // --------------------
    localparam int IN_OC = 0;
    localparam int IN_WOC = 1;
    localparam int IN_BAL = 2;
    localparam int IN_UV = 3;
    localparam int IN_OV = 4;
    localparam int IN_BELOW_TGT = 5;
    localparam int IN_CORE_WARN = 6;
    localparam int IN_NB_WARN = 7;
    localparam int IN_CORE_SHUT = 8;
    localparam int IN_NB_SHUT = 9;
    localparam int IN_OTHER = 10;
    localparam int IN_ENABLE = 11;
    localparam int IN_POR_OK = 12;
    localparam int IN_SCLK = 13;
    localparam int IN_SDATA = 14;
    localparam int IN_COUNT = 15;

    // --------------------
    // Serial packet bit positions
    // --------------------
    localparam logic [4:0] BIT_CORE_SEL = 5'h06;
    localparam logic [4:0] BIT_NB_SEL = 5'h07;
    localparam logic [4:0] BIT_TELEM_FN = 5'h15;
    localparam logic [4:0] PACKET_BITS = 5'h1b;

    // --------------------
    // Register map
    // --------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_FAULTS = 4'h8;
    localparam logic [3:0] ADDR_TELEM = 4'hc;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam int EVT_OC = 0;
    localparam int EVT_FAULT = 1;
    localparam int EVT_THERM = 2;
    localparam int EVT_TELEM = 3;
    localparam int EVT_COUNT = 4;

    localparam logic [7:0] PERCENT_FULL = 8'h64;
    localparam logic [7:0] PERCENT_MAX = 8'hff;

    typedef enum logic [1:0] {
        TELEM_VOLT_CURR,
        TELEM_VOLT_ONLY,
        TELEM_OFF
    } telemetry_mode_type;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_FAULT
    } run_state_type;

    typedef struct packed {
        logic overcurrent_fault;
        logic severe_overcurrent_fault;
        logic balance;
        logic undervoltage;
        logic overvoltage;
        logic thermal;
        logic other_vr;
    } fault_flags_type;

    localparam fault_flags_type NO_FAULTS = '0;
endpackage : vr_fault_pkg

// file: logic/vr_fault_supervisor.sv
// Fault supervision, throttle alert and telemetry mode control.
// Functional notes
// - Decode telemetry bits: 101 volt+current, 100 volt only, 110 off, 111 reserved.
// - Report load percent, full load at the 1.2V monitor level, proportional below.
// - Pull throttle alert low within 2us of an overcurrent detection.
// - Overcurrent held for 7.5us to 11us flags an overcurrent fault.
// - Overcurrent fault tri-states phases, shuts down, drops power good, flags other output.
// - Overcurrent dropping before timeout clears the timer and releases the alert.
// - Severe overcurrent shuts down at once and flags the other output.
// - Phase mismatch over 9mV for 1ms latches a balance fault.
// - Output 325mV under target latches undervoltage, drops power good, tri-states.
// - Overvoltage drops power good, low side on until below target, then tri-state.
// - Overvoltage pull-down repeats whenever the output rises above threshold again.
// - Temperature sense at or below 640mV pulls throttle alert low.
// - Up/down thermal counter, shutdown after at least 100us.
// - Warning compare moves 20mV to the reset level while tripped.
// - Alert released only when both temperature senses exceed the reset level.
// - Temperature at or below 580mV latches thermal fault and shuts both outputs.
// - Faults stay latched until enable or supply drops; then soft-start.
// - Telemetry mode applies only after the stop condition ends the packet.
`timescale 1ns/1ps
module vr_fault_supervisor
    import vr_fault_pkg::*;
#(
    parameter int LOAD_CURRENT_MONITOR_W = 10,
    parameter int LOAD_CURRENT_MONITOR_FULL_CODE = 800,
    parameter int OC_TIMER = OC_TIMER_CYC,
    parameter int THERM_SHUT = THERM_SHUT_CYC,
    parameter int BAL_TIME = BAL_FAULT_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic overcurrent_cmp_i,
    input wire logic severe_overcurrent_cmp_i,
    input wire logic phase_mismatch_cmp_i,
    input wire logic undervoltage_cmp_i,
    input wire logic overvoltage_cmp_i,
    input wire logic below_target_cmp_i,
    input wire logic core_temp_warn_cmp_i,
    input wire logic nb_temp_sense_warn_cmp_i,
    input wire logic core_temp_shut_cmp_i,
    input wire logic nb_temp_sense_shut_cmp_i,
    input wire logic other_vr_fault_i,
    input wire logic enable_i,
    input wire logic por_ok_i,
    input wire logic serial_control_clock_i,
    input wire logic serial_control_data_i,
    input wire logic [LOAD_CURRENT_MONITOR_W-1:0] load_current_monitor_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    output logic throttle_alert_n_o,
    output logic power_good_out_o,
    output logic phase_tristate_o,
    output logic low_side_on_o,
    output logic shutdown_o,
    output logic other_vr_fault_o,
    output logic temp_thresh_reset_o,
    output logic soft_start_o,
    output telemetry_mode_type telemetry_mode_o,
    output logic [7:0] load_percent_o,
    output fault_flags_type fault_flags_o
);
    // --------------------
    // Parameter checks
    // --------------------
    if (LOAD_CURRENT_MONITOR_W < 2 || LOAD_CURRENT_MONITOR_W > 16 || LOAD_CURRENT_MONITOR_FULL_CODE < 1 || LOAD_CURRENT_MONITOR_FULL_CODE >= (1 << LOAD_CURRENT_MONITOR_W)
        || OC_TIMER < 1 || THERM_SHUT < 1 || BAL_TIME < 1) begin : g_param_check
        $error("vr_fault_supervisor: unsupported parameter values");
    end

    localparam int OCW = $clog2(OC_TIMER + 1);
    localparam int THW = $clog2(THERM_SHUT + 1);
    localparam int BLW = $clog2(BAL_TIME + 1);

    // --------------------
    // Input synchronisers
    // --------------------
    wire [IN_COUNT-1:0] raw_in = {serial_control_data_i, serial_control_clock_i, por_ok_i,
        enable_i, other_vr_fault_i, nb_temp_sense_shut_cmp_i, core_temp_shut_cmp_i,
        nb_temp_sense_warn_cmp_i, core_temp_warn_cmp_i, below_target_cmp_i,
        overvoltage_cmp_i, undervoltage_cmp_i, phase_mismatch_cmp_i,
        severe_overcurrent_cmp_i, overcurrent_cmp_i};
    logic [IN_COUNT-1:0] sync_a;
    logic [IN_COUNT-1:0] sync_b;

    genvar gi;
    generate
        for (gi = 0; gi < IN_COUNT; gi++) begin : g_sync
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // --------------------
    // Enable, state and fault latch
    // --------------------
    run_state_type state;
    run_state_type next_state;
    fault_flags_type faults;
    fault_flags_type next_faults;
    logic [OCW-1:0] oc_count;
    logic [THW-1:0] therm_count;
    logic [BLW-1:0] bal_count;
    logic alert_hot;
    logic ov_pull;

    wire powered = sync_b[IN_ENABLE] & sync_b[IN_POR_OK];
    wire oc_now = sync_b[IN_OC];
    wire oc_expired = oc_now && oc_count >= OCW'(OC_TIMER - 1);
    wire bal_expired = sync_b[IN_BAL] && bal_count >= BLW'(BAL_TIME - 1);
    wire any_warn = sync_b[IN_CORE_WARN] | sync_b[IN_NB_WARN];
    wire therm_expired = any_warn && therm_count >= THW'(THERM_SHUT - 1);
    wire therm_shut = sync_b[IN_CORE_SHUT] | sync_b[IN_NB_SHUT];
    wire hard_fault = |{faults.overcurrent_fault, faults.severe_overcurrent_fault,
        faults.balance, faults.undervoltage, faults.thermal, faults.other_vr};

    always_comb begin
        next_faults = faults;
        next_faults.overcurrent_fault = faults.overcurrent_fault | oc_expired;
        next_faults.severe_overcurrent_fault = faults.severe_overcurrent_fault
            | sync_b[IN_WOC];
        next_faults.balance = faults.balance | bal_expired;
        next_faults.undervoltage = faults.undervoltage | sync_b[IN_UV];
        next_faults.overvoltage = faults.overvoltage | sync_b[IN_OV];
        next_faults.thermal = faults.thermal | therm_shut | therm_expired;
        next_faults.other_vr = faults.other_vr | sync_b[IN_OTHER];
    end

    always_comb begin
        case (state)
            ST_OFF: next_state = powered ? ST_RUN : ST_OFF;
            ST_RUN: next_state = !powered ? ST_OFF : (next_faults != NO_FAULTS ? ST_FAULT : ST_RUN);
            ST_FAULT: next_state = powered ? ST_FAULT : ST_OFF;
            default: next_state = ST_OFF;
        endcase
    end

    // Faults clear only while unpowered, so a retry needs enable or supply to drop and return.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_OFF;
            faults <= NO_FAULTS;
        end else begin
            state <= next_state;
            faults <= (state == ST_OFF) ? NO_FAULTS : next_faults;
        end
    end

    // --------------------
    // Fault timers
    // --------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            oc_count <= '0;
            bal_count <= '0;
            therm_count <= '0;
        end else begin
            oc_count <= (oc_now && !oc_expired) ? oc_count + 1'b1 : '0;
            bal_count <= (sync_b[IN_BAL] && !bal_expired) ? bal_count + 1'b1 : '0;
            if (any_warn && !therm_expired) begin
                therm_count <= therm_count + 1'b1;
            end else if (!any_warn && therm_count != '0) begin
                therm_count <= therm_count - 1'b1;
            end
        end
    end

    // --------------------
    // Thermal alert with hysteresis
    // --------------------
    // The comparators see the level chosen by temp_thresh_reset_o, which follows alert_hot.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            alert_hot <= 1'b0;
        end else if (!alert_hot && any_warn) begin
            alert_hot <= 1'b1;
        end else if (alert_hot && !any_warn) begin
            alert_hot <= 1'b0;
        end
    end

    // --------------------
    // Overvoltage pull-down
    // --------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ov_pull <= 1'b0;
        end else if (state == ST_OFF) begin
            ov_pull <= 1'b0;
        end else if (sync_b[IN_OV]) begin
            ov_pull <= 1'b1;
        end else if (sync_b[IN_BELOW_TGT]) begin
            ov_pull <= 1'b0;
        end
    end

    // --------------------
    // Load percentage
    // --------------------
    wire [LOAD_CURRENT_MONITOR_W+7:0] pct_full = ({8'h00, load_current_monitor_i} * (LOAD_CURRENT_MONITOR_W + 8)'(PERCENT_FULL))
        / (LOAD_CURRENT_MONITOR_W + 8)'(LOAD_CURRENT_MONITOR_FULL_CODE);
    wire [7:0] pct_sat = (pct_full > (LOAD_CURRENT_MONITOR_W + 8)'(PERCENT_MAX)) ? PERCENT_MAX : pct_full[7:0];

    // --------------------
    // Serial control framing
    // --------------------
    logic sclk_prev;
    logic sdata_prev;
    logic in_packet;
    logic [4:0] bit_count;
    logic core_sel;
    logic nb_sel;
    logic telem_fn;
    wire sclk_rise = sync_b[IN_SCLK] & ~sclk_prev;
    wire start_cond = sclk_prev & sync_b[IN_SCLK] & sdata_prev & ~sync_b[IN_SDATA];
    wire stop_cond = sclk_prev & sync_b[IN_SCLK] & ~sdata_prev & sync_b[IN_SDATA];
    wire [4:0] bit_num = bit_count + 5'h01;
    // The clock rise that opens the stop is counted too, so a full packet ends one past it.
    wire packet_done = in_packet && stop_cond && bit_count == PACKET_BITS + 5'h01;

    function automatic logic [2:0] decode_telem(input logic fn, input logic core,
        input logic nb);
        // Bit 2 marks a valid command, bits 1:0 the mode.
        if (!fn || (core && nb)) begin
            decode_telem = {1'b0, TELEM_OFF};
        end else if (core) begin
            decode_telem = {1'b1, TELEM_OFF};
        end else if (nb) begin
            decode_telem = {1'b1, TELEM_VOLT_CURR};
        end else begin
            decode_telem = {1'b1, TELEM_VOLT_ONLY};
        end
    endfunction : decode_telem

    wire [2:0] telem_cmd = decode_telem(telem_fn, core_sel, nb_sel);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_prev <= 1'b0;
            sdata_prev <= 1'b0;
            in_packet <= 1'b0;
            bit_count <= '0;
            core_sel <= 1'b0;
            nb_sel <= 1'b0;
            telem_fn <= 1'b0;
        end else begin
            sclk_prev <= sync_b[IN_SCLK];
            sdata_prev <= sync_b[IN_SDATA];
            if (start_cond) begin
                in_packet <= 1'b1;
                bit_count <= '0;
            end else if (stop_cond) begin
                in_packet <= 1'b0;
            end else if (in_packet && sclk_rise) begin
                bit_count <= bit_num;
                if (bit_num == BIT_CORE_SEL) begin
                    core_sel <= sync_b[IN_SDATA];
                end
                if (bit_num == BIT_NB_SEL) begin
                    nb_sel <= sync_b[IN_SDATA];
                end
                if (bit_num == BIT_TELEM_FN) begin
                    telem_fn <= sync_b[IN_SDATA];
                end
            end
        end
    end

    // --------------------
    // Registers and interrupt
    // --------------------
    logic [EVT_COUNT-1:0] status;
    logic [EVT_COUNT-1:0] mask;
    logic [EVT_COUNT-1:0] events;
    logic oc_prev;
    wire fault_rise = (state == ST_RUN) && (next_state == ST_FAULT);
    wire [EVT_COUNT-1:0] new_events = {packet_done & telem_cmd[2], any_warn & ~alert_hot,
        fault_rise, oc_now & ~oc_prev};
    wire status_read = reg_read_i && reg_addr_i == ADDR_STATUS;
    wire [31:0] rd_value = (reg_addr_i == ADDR_STATUS) ? {28'h0, status}
        : (reg_addr_i == ADDR_MASK) ? {28'h0, mask}
        : (reg_addr_i == ADDR_FAULTS) ? {25'h0, faults}
        : (reg_addr_i == ADDR_TELEM) ? {22'h0, telemetry_mode_o, load_percent_o}
        : 32'h0;

    assign events = new_events;

    // A new event in the read cycle survives the clear.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            status <= '0;
            mask <= MASK_RESET;
            oc_prev <= 1'b0;
            reg_rdata_o <= '0;
            irq_o <= 1'b0;
        end else begin
            oc_prev <= oc_now;
            status <= (status_read ? '0 : status) | events;
            if (reg_write_i && reg_addr_i == ADDR_MASK) begin
                mask <= reg_wdata_i[EVT_COUNT-1:0];
            end
            reg_rdata_o <= reg_read_i ? rd_value : '0;
            irq_o <= |(((status_read ? '0 : status) | events) & mask);
        end
    end

    // --------------------
    // Output flops
    // --------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            throttle_alert_n_o <= 1'b1;
            power_good_out_o <= 1'b0;
            phase_tristate_o <= 1'b1;
            low_side_on_o <= 1'b0;
            shutdown_o <= 1'b1;
            other_vr_fault_o <= 1'b0;
            temp_thresh_reset_o <= 1'b0;
            soft_start_o <= 1'b0;
            telemetry_mode_o <= TELEM_VOLT_CURR;
            load_percent_o <= '0;
            fault_flags_o <= NO_FAULTS;
        end else begin
            throttle_alert_n_o <= !(oc_now || alert_hot);
            power_good_out_o <= (state == ST_RUN) && next_faults == NO_FAULTS;
            phase_tristate_o <= (state == ST_OFF) || hard_fault
                || (faults.overvoltage && !ov_pull);
            low_side_on_o <= ov_pull;
            shutdown_o <= (state == ST_OFF) || hard_fault;
            other_vr_fault_o <= faults.overcurrent_fault | faults.severe_overcurrent_fault
                | faults.thermal;
            temp_thresh_reset_o <= alert_hot;
            soft_start_o <= (state == ST_OFF) && powered;
            if (packet_done && telem_cmd[2]) begin
                telemetry_mode_o <= telemetry_mode_type'(telem_cmd[1:0]);
            end
            load_percent_o <= pct_sat;
            fault_flags_o <= faults;
        end
    end
endmodule : vr_fault_supervisor

// file: testbench/vr_fault_supervisor_asserts.sv
// Concurrent checks on the protection outputs of the fault supervisor.
`timescale 1ns/1ps
module vr_fault_supervisor_asserts
    import vr_fault_pkg::*;
#(
    parameter int OC_TIMER = OC_TIMER_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic overcurrent_cmp_i,
    input wire logic severe_overcurrent_cmp_i,
    input wire logic overvoltage_cmp_i,
    input wire logic core_temp_shut_cmp_i,
    input wire logic enable_i,
    input wire logic por_ok_i,
    input wire logic throttle_alert_n_o,
    input wire logic power_good_out_o,
    input wire logic phase_tristate_o,
    input wire logic low_side_on_o,
    input wire logic shutdown_o,
    input wire logic other_vr_fault_o,
    input wire fault_flags_type fault_flags_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // The run length follows the raw input, so it leads the design's synchronised view.
    logic [15:0] oc_run;
    logic shut_all;
    assign shut_all = shutdown_o && phase_tristate_o && !power_good_out_o && other_vr_fault_o;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            oc_run <= 16'h0000;
        end else begin
            oc_run <= (overcurrent_cmp_i && enable_i && por_ok_i) ? oc_run + 16'h0001 : '0;
        end
    end
    property p_oc_alert;
        (power_good_out_o && overcurrent_cmp_i) [*5] |-> !throttle_alert_n_o;
    endproperty
    a_oc_alert: assert property (p_oc_alert) else $error("alert late on overcurrent");
    property p_oc_min;
        $rose(fault_flags_o.overcurrent_fault) |-> oc_run >= 16'(OC_TIMER);
    endproperty
    a_oc_min: assert property (p_oc_min) else $error("overcurrent fault too early");
    property p_oc_max;
        oc_run >= 16'(OC_TIMER + 8) |-> fault_flags_o.overcurrent_fault;
    endproperty
    a_oc_max: assert property (p_oc_max) else $error("overcurrent fault too late");
    property p_oc_act;
        $rose(fault_flags_o.overcurrent_fault) |-> ##[0:4] shut_all;
    endproperty
    a_oc_act: assert property (p_oc_act) else $error("overcurrent fault not acted on");
    property p_woc;
        (power_good_out_o && severe_overcurrent_cmp_i) |-> ##[1:6] shut_all;
    endproperty
    a_woc: assert property (p_woc) else $error("severe overcurrent not acted on");
    property p_ov;
        (power_good_out_o && overvoltage_cmp_i) |-> ##[1:6] (low_side_on_o && !power_good_out_o);
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage pull-down missing");
    property p_therm;
        (power_good_out_o && core_temp_shut_cmp_i) |-> ##[1:6] (fault_flags_o.thermal && shut_all);
    endproperty
    a_therm: assert property (p_therm) else $error("thermal shutdown missing");
    property p_pg;
        (fault_flags_o != NO_FAULTS) |=> !power_good_out_o;
    endproperty
    a_pg: assert property (p_pg) else $error("power good high with a fault");
    property p_latch;
        (enable_i && por_ok_i) [*4] ##0 (fault_flags_o != NO_FAULTS) |=> (fault_flags_o != NO_FAULTS);
    endproperty
    a_latch: assert property (p_latch) else $error("fault cleared while enabled");
endmodule : vr_fault_supervisor_asserts

bind vr_fault_supervisor vr_fault_supervisor_asserts #(.OC_TIMER(OC_TIMER)) u_chk (
    .clk_i, .reset_i, .overcurrent_cmp_i, .severe_overcurrent_cmp_i, .overvoltage_cmp_i,
    .core_temp_shut_cmp_i, .enable_i, .por_ok_i, .throttle_alert_n_o, .power_good_out_o,
    .phase_tristate_o, .low_side_on_o, .shutdown_o, .other_vr_fault_o, .fault_flags_o
);

// file: testbench/vr_host_link.sv
// Host model for the serial control link: start, data bits, stop.
`timescale 1ns/1ps
module vr_host_link (
    output logic sclk_o,
    output logic sdata_o
);
    // Both lines idle high as pulled up; the clock stands still between frames.
    initial begin
        sclk_o = 1'b1;
        sdata_o = 1'b1;
    end
    task automatic frame(input logic [27:1] pkt, input int n);
        #1.3 sdata_o = 1'b0;
        #16 sclk_o = 1'b0;
        for (int k = 1; k <= n; k++) begin
            sdata_o = pkt[k];
            #16 sclk_o = 1'b1;
            #16 sclk_o = 1'b0;
        end
    endtask : frame
    task automatic stop();
        sdata_o = 1'b0;
        #16 sclk_o = 1'b1;
        #16 sdata_o = 1'b1;
    endtask : stop
endmodule : vr_host_link

// file: testbench/vr_fault_supervisor_tb_top.sv
// Self-checking bench for the fault supervisor.
`timescale 1ns/1ps
module vr_fault_supervisor_tb_top;
    import vr_fault_pkg::*;
    localparam int FULL = 400;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [8:0] cmp = '0;
    logic ov = 1'b0, below = 1'b0, en = 1'b1, por = 1'b1, we = 1'b0, re = 1'b0;
    logic [9:0] load_current_monitor = '0;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0, d, seed = 32'hb815b45d;
    logic [27:1] pkt;
    logic [5:0] tv [6] = '{6'h14, 6'h26, 6'h27, 6'h21, 6'h2d, 6'h05};
    logic [1:0] em = 2'h0;
    logic sclk, sdata, irq_o, throttle_alert_n_o, power_good_out_o, phase_tristate_o;
    logic low_side_on_o, shutdown_o, other_vr_fault_o, temp_thresh_reset_o, soft_start_o;
    logic [31:0] reg_rdata_o;
    logic [7:0] load_percent_o;
    telemetry_mode_type telemetry_mode_o;
    fault_flags_type fault_flags_o;
    int miscompares = 0, compares = 0, cycles = 0;
    int fb [9] = '{0, 1, 2, 3, 4, 8, 5, 6, 7};
    int fn [9] = '{30, 4, 60, 4, 60, 60, 4, 4, 4};
    logic [6:0] fe [9] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h02, 7'h02, 7'h02, 7'h02, 7'h01};
    vr_host_link u_host (.sclk_o(sclk), .sdata_o(sdata));
    vr_fault_supervisor #(.LOAD_CURRENT_MONITOR_FULL_CODE(FULL), .OC_TIMER(20), .THERM_SHUT(50), .BAL_TIME(50))
    u_dut (.clk_i, .reset_i, .overcurrent_cmp_i(cmp[0]), .severe_overcurrent_cmp_i(cmp[1]),
        .phase_mismatch_cmp_i(cmp[2]), .undervoltage_cmp_i(cmp[3]), .overvoltage_cmp_i(ov),
        .below_target_cmp_i(below), .core_temp_warn_cmp_i(cmp[4]),
        .nb_temp_sense_warn_cmp_i(cmp[8]), .core_temp_shut_cmp_i(cmp[5]),
        .nb_temp_sense_shut_cmp_i(cmp[6]), .other_vr_fault_i(cmp[7]), .enable_i(en),
        .por_ok_i(por), .serial_control_clock_i(sclk), .serial_control_data_i(sdata),
        .load_current_monitor_i(load_current_monitor), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(we), .reg_read_i(re), .reg_rdata_o, .irq_o, .throttle_alert_n_o,
        .power_good_out_o, .phase_tristate_o, .low_side_on_o, .shutdown_o, .other_vr_fault_o,
        .temp_thresh_reset_o, .soft_start_o, .telemetry_mode_o, .load_percent_o, .fault_flags_o);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] exp_pct(input logic [9:0] c);
        int v;
        v = int'(c) * 100 / FULL;
        return (v > 255) ? 8'hff : v[7:0];
    endfunction : exp_pct
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    task automatic rw(input logic [3:0] a, input logic [31:0] dw, input logic wr);
        @(posedge clk_i);
        addr <= a;
        wdata <= dw;
        we <= wr;
        re <= !wr;
        @(posedge clk_i);
        we <= 1'b0;
        re <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rw
    task automatic recover(input int k);
        cmp <= '0;
        ov <= 1'b0;
        below <= 1'b0;
        if (k % 2 == 1) en <= 1'b0;
        else por <= 1'b0;
        cyc(8);
        en <= 1'b1;
        por <= 1'b1;
        cyc(3);
        #1 chk("soft start", 1'b1, soft_start_o);
        cyc(13);
        chk("restart", 8'h80, {power_good_out_o, fault_flags_o});
    endtask : recover
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Long holds are counted on shortened timers, so the ceiling stays small.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        cyc(10);
        reset_i <= 1'b0;
        cyc(16);
        chk("power good", 1'b1, power_good_out_o);
        rw(ADDR_MASK, '0, 1'b0);
        chk("mask reset", {28'h0, MASK_RESET}, d);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            pkt = seed[26:0];
            pkt[8:1] = 8'h03;
            {pkt[21], pkt[6], pkt[7]} = tv[i][2:0];
            u_host.frame(pkt, tv[i][3] ? 26 : 27);
            cyc(8);
            chk("mode before stop", em, telemetry_mode_o);
            u_host.stop();
            cyc(8);
            em = tv[i][5:4];
            chk("mode", em, telemetry_mode_o);
        end
        chk("irq masked", 1'b0, irq_o);
        rw(ADDR_MASK, 32'h8, 1'b1);
        cyc(3);
        chk("irq", 1'b1, irq_o);
        rw(ADDR_STATUS, '0, 1'b0);
        chk("status", 1'b1, d[3]);
        cyc(3);
        chk("irq cleared", 1'b0, irq_o);
        rw(4'h2, '0, 1'b0);
        chk("unmapped", '0, d);
        $display("Done: telemetry and registers");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            load_current_monitor <= (i == 0) ? 10'h3ff : (i == 1) ? 10'(FULL) : seed[9:0];
            cyc(3);
            chk("load percent", exp_pct(load_current_monitor), load_percent_o);
        end
        rw(ADDR_TELEM, '0, 1'b0);
        chk("telemetry reg", {22'h0, em, exp_pct(load_current_monitor)}, d);
        cmp[0] <= 1'b1;
        cyc(8);
        chk("alert on overcurrent", 1'b0, throttle_alert_n_o);
        cmp[0] <= 1'b0;
        cyc(8);
        chk("alert release", 8'h80, {throttle_alert_n_o, fault_flags_o});
        {cmp[8], cmp[4]} <= 2'b11;
        cyc(6);
        chk("warn", 2'b01, {throttle_alert_n_o, temp_thresh_reset_o});
        cmp[4] <= 1'b0;
        cyc(6);
        chk("one warn left", 1'b0, throttle_alert_n_o);
        cmp[8] <= 1'b0;
        cyc(6);
        chk("warn release", 2'b10, {throttle_alert_n_o, temp_thresh_reset_o});
        repeat (2) begin
            cmp[4] <= 1'b1;
            cyc(40);
            cmp[4] <= 1'b0;
            cyc(40);
        end
        chk("thermal count down", '0, fault_flags_o);
        $display("Done: alerts");
        for (int i = 0; i < 9; i++) begin
            cmp[fb[i]] <= 1'b1;
            cyc(fn[i]);
            cmp <= '0;
            cyc(4);
            chk("fault", {3'b011, fe[i]},
                {power_good_out_o, phase_tristate_o, shutdown_o, fault_flags_o});
            recover(i);
        end
        ov <= 1'b1;
        cyc(6);
        ov <= 1'b0;
        cyc(6);
        chk("overvoltage hold", 4'b1000,
            {low_side_on_o, power_good_out_o, phase_tristate_o, shutdown_o});
        below <= 1'b1;
        cyc(6);
        chk("overvoltage release", 2'b01, {low_side_on_o, phase_tristate_o});
        below <= 1'b0;
        ov <= 1'b1;
        cyc(6);
        chk("overvoltage again", 1'b1, low_side_on_o);
        recover(0);
        $display("Done: faults");
        wrap_up();
    end
endmodule : vr_fault_supervisor_tb_top
